// File: common/banked_mem_defs.svh
`ifndef BANKED_MEM_DEFS_SVH
`define BANKED_MEM_DEFS_SVH

// special-function locations
`define ADDR_INDIRECT_FIRST   8'h00
`define ADDR_POINTER_FIRST    8'h01
`define ADDR_INDIRECT_SECOND  8'h02
`define ADDR_POINTER_SECOND   8'h03
`define ADDR_BANK_SELECT      8'h04
`define ADDR_NV_CONTROL       8'h40

// general-purpose windows
`define GP_BANK0_LOW          8'h60
`define GP_BANK1_LOW          8'h80
`define GP_BANK1_BASE         9'h0a0
`define MEM_DEPTH             288
`define MEM_ADDR_W            9

// reset values
`define RESET_POINTER         8'h00
`define RESET_BANK            1'b0
`define RESET_NV_CONTROL      8'h00
`define READ_ZERO             8'h00

`endif

// File: common/banked_mem_pkg.sv
package banked_mem_pkg;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } mem_rsp_t;

    typedef enum logic [1:0] {
        TGT_NONE,
        TGT_GP,
        TGT_SFR
    } target_kind_t;

endpackage

// File: core/gp_ram.sv
`timescale 1ns/1ns
`default_nettype none
`include "banked_mem_defs.svh"

module gp_ram (
    input  wire logic                     clock,
    input  wire logic                     we,
    input  wire logic [`MEM_ADDR_W-1:0]   addr,
    input  wire logic [7:0]               wdata,
    output logic      [7:0]               rdata
);
    logic [7:0] mem [0:`MEM_DEPTH-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clock) begin
        rdata <= mem[addr];
    end
endmodule

`default_nettype wire

// File: core/banked_data_memory_indirect.sv
// Behaviour
// - data memory is volatile storage, one byte per location
// - address space starts at zero, special-function area below general-purpose area
// - special-function registers same in every bank; control register at 40H bank 1 only
// - bank reached is chosen by loading the bank select pointer
// - 288 bytes total; general-purpose 60H-FFH bank 0, 80H-FFH bank 1
// - indirect port access goes to the location its pointer holds
// - first indirect port reaches bank 0 only
// - second indirect port reaches any bank
// - indirect read aimed at an indirect port returns zero
// - indirect write aimed at an indirect port does nothing
`timescale 1ns/1ns
`default_nettype none
`include "banked_mem_defs.svh"

module banked_data_memory_indirect
    import banked_mem_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     rst,
    input  wire mem_req_t req,
    output mem_rsp_t      rsp,
    output logic [7:0]    memory_pointer_first,
    output logic [7:0]    memory_pointer_second,
    output logic          bank_select_pointer,
    output logic [7:0]    nonvolatile_control_reg
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // the two port addresses themselves
    function automatic logic is_indirect(input logic [7:0] a);
        is_indirect = (a == `ADDR_INDIRECT_FIRST) || (a == `ADDR_INDIRECT_SECOND);
    endfunction

    // true where the bank/address pair lands in general-purpose storage
    function automatic logic gp_hit(input logic bank, input logic [7:0] a);
        gp_hit = bank ? (a >= `GP_BANK1_LOW) : (a >= `GP_BANK0_LOW);
    endfunction

    // maps a bank/address pair to a general-purpose ram index
    function automatic logic [`MEM_ADDR_W-1:0] gp_index(input logic bank,
                                                       input logic [7:0] a);
        gp_index = bank ? (`GP_BANK1_BASE + {1'b0, a - `GP_BANK1_LOW})
                        : {1'b0, a - `GP_BANK0_LOW};
    endfunction

    // ------------------------------------------------------------
    // effective target
    // ------------------------------------------------------------
    logic         effBank;
    logic [7:0]   effAddr;
    logic         viaPort;
    logic         selfRef;
    target_kind_t kind;

    // port accesses are redirected; everything else keeps its own address
    always_comb begin
        effBank = bank_select_pointer;
        effAddr = req.addr;
        viaPort = 1'b0;
        if (req.addr == `ADDR_INDIRECT_FIRST) begin
            effAddr = memory_pointer_first;
            effBank = 1'b0;
            viaPort = 1'b1;
        end else if (req.addr == `ADDR_INDIRECT_SECOND) begin
            effAddr = memory_pointer_second;
            effBank = bank_select_pointer;
            viaPort = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // target classification
    // ------------------------------------------------------------
    // a port aimed at either port has no storage behind it
    assign selfRef = viaPort && is_indirect(effAddr);

    always_comb begin
        if (selfRef) begin
            kind = TGT_NONE;
        end else if (gp_hit(effBank, effAddr)) begin
            kind = TGT_GP;
        end else begin
            kind = TGT_SFR;
        end
    end

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    logic doWrite;
    logic sfrWrite;
    logic ramWrite;

    // a self-referencing port write falls into neither strobe
    assign doWrite  = req.valid && req.write;
    assign sfrWrite = doWrite && (kind == TGT_SFR);
    assign ramWrite = doWrite && (kind == TGT_GP);

    // ------------------------------------------------------------
    // special-function registers held here
    // ------------------------------------------------------------
    // shared by both banks: the address alone selects them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memory_pointer_first <= `RESET_POINTER;
        end else if (sfrWrite && effAddr == `ADDR_POINTER_FIRST) begin
            memory_pointer_first <= req.wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memory_pointer_second <= `RESET_POINTER;
        end else if (sfrWrite && effAddr == `ADDR_POINTER_SECOND) begin
            memory_pointer_second <= req.wdata;
        end
    end

    // only bit 0 is kept: two banks need no more
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bank_select_pointer <= `RESET_BANK;
        end else if (sfrWrite && effAddr == `ADDR_BANK_SELECT) begin
            bank_select_pointer <= req.wdata[0];
        end
    end

    // the control register only answers in bank 1
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nonvolatile_control_reg <= `RESET_NV_CONTROL;
        end else if (sfrWrite && effBank && effAddr == `ADDR_NV_CONTROL) begin
            nonvolatile_control_reg <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // general-purpose ram
    // ------------------------------------------------------------
    logic [`MEM_ADDR_W-1:0] ramIndex;
    logic [7:0]             ramData;

    // other targets park the index at zero so the ram never reads past its end
    assign ramIndex = (kind == TGT_GP) ? gp_index(effBank, effAddr) : '0;

    // a read in the cycle of a write to the same index sees the old byte
    gp_ram u_ram (
        .clock (clock),
        .we    (ramWrite),
        .addr  (ramIndex),
        .wdata (req.wdata),
        .rdata (ramData)
    );

    // ------------------------------------------------------------
    // read return, first stage
    // ------------------------------------------------------------
    target_kind_t readKind;
    logic [7:0]   readSfr;
    logic         readValid;
    logic [7:0]   next_sfr;

    // unmapped special-function locations read as zero
    always_comb begin
        case (effAddr)
            `ADDR_POINTER_FIRST:  next_sfr = memory_pointer_first;
            `ADDR_POINTER_SECOND: next_sfr = memory_pointer_second;
            `ADDR_BANK_SELECT:    next_sfr = {7'h00, bank_select_pointer};
            `ADDR_NV_CONTROL:     next_sfr = effBank ? nonvolatile_control_reg
                                                     : `READ_ZERO;
            default:              next_sfr = `READ_ZERO;
        endcase
    end

    // writes give no answer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readValid <= 1'b0;
        end else begin
            readValid <= req.valid && !req.write;
        end
    end

    // kind and sfr byte travel alongside the ram read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readKind <= TGT_NONE;
            readSfr  <= `READ_ZERO;
        end else begin
            readKind <= kind;
            readSfr  <= next_sfr;
        end
    end

    // ------------------------------------------------------------
    // read return, output stage
    // ------------------------------------------------------------
    // the extra stage keeps every output on a flip-flop at the cost of one cycle
    logic [7:0] next_rdata;

    always_comb begin
        case (readKind)
            TGT_GP:  next_rdata = ramData;
            TGT_SFR: next_rdata = readSfr;
            default: next_rdata = `READ_ZERO;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp.valid <= 1'b0;
            rsp.rdata <= `READ_ZERO;
        end else begin
            rsp.valid <= readValid;
            rsp.rdata <= next_rdata;
        end
    end
endmodule

`default_nettype wire

// File: test/banked_mem_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checks of the banked data memory
// ----------------------------------------
module banked_mem_chk
    import banked_mem_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire mem_req_t   req,
    input  wire mem_rsp_t   rsp,
    input  wire logic [7:0] memory_pointer_first,
    input  wire logic [7:0] memory_pointer_second,
    input  wire logic       bank_select_pointer,
    input  wire logic [7:0] nonvolatile_control_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence rd(logic [7:0] a); req.valid && !req.write && req.addr == a; endsequence
    sequence wr(logic [7:0] a); req.valid && req.write && req.addr == a; endsequence
    chk_read_answer: assert property (
        req.valid && !req.write |-> ##2 rsp.valid)
        else $error("read not answered");
    chk_write_silent: assert property (
        !(req.valid && !req.write) |-> ##2 !rsp.valid)
        else $error("answer without read");
    chk_bank_load: assert property (
        wr(8'h04) |=> bank_select_pointer == $past(req.wdata[0]))
        else $error("bank not loaded");
    chk_second_ptr: assert property (
        wr(8'h03) |=> memory_pointer_second == $past(req.wdata))
        else $error("second pointer not loaded");
    chk_nv_ignore: assert property (
        wr(8'h40) ##0 !bank_select_pointer |=> $stable(nonvolatile_control_reg))
        else $error("control written in bank 0");
    chk_nv_zero: assert property (
        rd(8'h40) ##0 !bank_select_pointer |-> ##2 rsp.rdata == 8'h00)
        else $error("control visible in bank 0");
    chk_self_read: assert property (
        rd(8'h00) ##0 memory_pointer_first == 8'h00 |-> ##2 rsp.rdata == 8'h00)
        else $error("self read not zero");
    chk_self_write: assert property (
        wr(8'h02) ##0 memory_pointer_second == 8'h02
        |=> $stable({memory_pointer_first, memory_pointer_second, bank_select_pointer}))
        else $error("self write had effect");
endmodule

bind banked_data_memory_indirect banked_mem_chk i_chk (
    .clock                   (clock),
    .rst                     (rst),
    .req                     (req),
    .rsp                     (rsp),
    .memory_pointer_first    (memory_pointer_first),
    .memory_pointer_second   (memory_pointer_second),
    .bank_select_pointer     (bank_select_pointer),
    .nonvolatile_control_reg (nonvolatile_control_reg)
);
`default_nettype wire

// File: test/core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// execution logic issuing memory requests
// ----------------------------------------
module core_model
    import banked_mem_pkg::*;
(
    input  wire logic     clock,
    output var mem_req_t  req,
    input  wire mem_rsp_t rsp
);
    initial req = '0;
    // released fields show inverted junk, not the last request
    // the answer stands in the second cycle after the taking edge
    task automatic access(input  logic       w,
                          input  logic [7:0] a,
                          input  logic [7:0] d,
                          output mem_rsp_t   r);
        @(negedge clock);
        req = '{1'b1, w, a, d};
        @(negedge clock);
        req = '{1'b0, ~w, ~a, ~d};
        @(negedge clock);
        r = rsp;
    endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import banked_mem_pkg::*;
;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    mem_req_t   req;
    mem_rsp_t   rsp;
    logic [7:0] mpA, mpB, nv;
    logic       bank;
    int         nErrors = 0, checkCount = 0, cycles = 0;
    banked_data_memory_indirect i_dut (.clock(clock), .rst(rst), .req(req), .rsp(rsp),
        .memory_pointer_first(mpA), .memory_pointer_second(mpB),
        .bank_select_pointer(bank), .nonvolatile_control_reg(nv));
    core_model i_core (.clock(clock), .req(req), .rsp(rsp));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        mem_rsp_t r;
        i_core.access(1'b1, a, d, r);
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp);
        mem_rsp_t r;
        i_core.access(1'b0, a, 8'h00, r);
        check("answer", {7'h0, r.valid}, 8'h01);
        check("read", r.rdata, exp);
    endtask
    task automatic t_direct();
        wr(8'h04, 8'h00);
        wr(8'h60, 8'h3c);
        wr(8'h80, 8'h11);
        wr(8'h04, 8'h01);
        wr(8'h80, 8'h22);
        wr(8'hff, 8'h44);
        rdc(8'h80, 8'h22);
        rdc(8'hff, 8'h44);
        rdc(8'h04, 8'h01);
        wr(8'h04, 8'h00);
        rdc(8'h80, 8'h11);
        rdc(8'h60, 8'h3c);
        $display("direct done");
    endtask
    task automatic t_indirect();
        wr(8'h04, 8'h01);
        wr(8'h01, 8'h90);
        check("pointer", mpA, 8'h90);
        wr(8'h00, 8'h5a);
        wr(8'h03, 8'h90);
        wr(8'h02, 8'ha5);
        rdc(8'h00, 8'h5a);
        rdc(8'h90, 8'ha5);
        wr(8'h04, 8'h00);
        rdc(8'h90, 8'h5a);
        rdc(8'h01, 8'h90);
        rdc(8'h03, 8'h90);
        rdc(8'h02, 8'h5a);
        $display("indirect done");
    endtask
    task automatic t_self();
        wr(8'h04, 8'h01);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h77);
        rdc(8'h00, 8'h00);
        wr(8'h03, 8'h02);
        wr(8'h02, 8'h77);
        rdc(8'h02, 8'h00);
        check("pointer", mpB, 8'h02);
        rdc(8'h90, 8'ha5);
        wr(8'h40, 8'ha5);
        check("control", nv, 8'ha5);
        wr(8'h04, 8'h00);
        wr(8'h40, 8'h3c);
        rdc(8'h40, 8'h00);
        check("control", nv, 8'ha5);
        $display("self and control done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        forever #2 clock = ~clock;
    end
    // the tests need about 120 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            nErrors++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_direct();
        t_indirect();
        t_self();
        summarize();
    end
endmodule
`default_nettype wire
